// >>> tick_timer.sv
// divider tap timer: counter, tick events, masks, flags and avalon slave
//
// Contract
// RL1 - seven-bit counter on 256 Hz, top four readable
// RL2 - events on 32, 8, 2 Hz falling edges
// RL3 - flag set regardless of mask bit
// RL4 - three read/write mask bits, one enables
// RL5 - masks clear to zero at reset
// RL6 - software writes masks only with interrupts off
// RL7 - flags readable, cleared right after read
// RL8 - writes to flags are ignored
// RL9 - software reads flags only with interrupts off
// RL10 - flags clear to zero at reset
// RL11 - four stages readable, writes ignored
// RL12 - readable timer value zero after reset
// RL13 - writing one restarts counter, zero does nothing
// RL14 - restart bit reads back zero
// RL15 - restart may set a flag spuriously
// RL16 - 2 Hz tap drives the watchdog clock
// RL17 - interrupt when any enabled flag set
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/100ps
module tick_timer #(
  parameter int CNT_W = 7
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // prescaler
  input wire logic tick_256hz,
  // register bus
  input wire tick_timer_pkg::avmm_req_s bus_req,
  output tick_timer_pkg::avmm_rsp_s bus_rsp,
  // to the processor and the watchdog
  output logic irq,
  output logic watchdog_clk_2hz
);
  import tick_timer_pkg::*;

  timer_state_s st_q;
  timer_state_s st_d;

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] fall;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;
  logic [READ_W-1:0] readback;
  logic req;
  logic acc_rd;
  logic acc_wr;
  logic wr_lane0;
  logic restart_pulse;

  // true when the byte address selects the given register index
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [IDX_W-1:0] idx);
    reg_hit = (addr == {idx, 2'b00});
  endfunction

  // read value for an address; unmapped and write-only registers read zero
  function automatic logic [DATA_W-1:0] read_value(input logic [ADDR_W-1:0] addr,
                                                   input logic [READ_W-1:0] taps,
                                                   input logic [EVT_W-1:0] mask,
                                                   input logic [EVT_W-1:0] flags);
    read_value = '0; // [RL14]
    if (reg_hit(addr, IDX_TAP_READBACK)) begin
      read_value[READ_W-1:0] = taps;
    end else if (reg_hit(addr, IDX_TICK_MASK)) begin
      read_value[EVT_W-1:0] = mask;
    end else if (reg_hit(addr, IDX_TICK_FLAGS)) begin
      read_value[EVT_W-1:0] = flags;
    end
  endfunction

  // bus handshake: every access waits exactly one cycle
  assign req = bus_req.read | bus_req.write;
  assign acc_rd = bus_req.read & st_q.done;
  assign acc_wr = bus_req.write & st_q.done;
  assign wr_lane0 = acc_wr & bus_req.byteenable[0];

  // writing zero to the restart bit does nothing
  assign restart_pulse = wr_lane0 & reg_hit(bus_req.address, IDX_RUN_CTRL)
                         & bus_req.writedata[BIT_RESTART]; // [RL13]

  tap_divider #(
    .CNT_W(CNT_W)
  ) u_div (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .tick(tick_256hz), // [RL1]
    .restart(restart_pulse), // [RL13]
    .count(count),
    .fall(fall)
  );

  // events: a restart that drops a high stage also counts as an edge
  assign evt_set[EVT_BIT32] = fall[TAP_EVT32]; // [RL2] [RL15]
  assign evt_set[EVT_BIT8] = fall[TAP_EVT8]; // [RL2] [RL15]
  assign evt_set[EVT_BIT2] = fall[TAP_EVT2]; // [RL2] [RL15]

  // the four slowest stages, 16 Hz down to 2 Hz
  assign readback = count[TAP_READ_LO +: READ_W]; // [RL1] [RL11]

  // flags clear on the read that returned them, or by the clear register
  always_comb begin
    evt_clr = '0;
    if (acc_rd) begin
      evt_clr = st_q.rd_flags; // [RL7]
    end
    if (wr_lane0 && reg_hit(bus_req.address, IDX_FLAG_CLEAR)) begin
      evt_clr = evt_clr | bus_req.writedata[EVT_W-1:0];
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.done = req & ~st_q.done;
    // sample read data one cycle ahead of the answer
    if (bus_req.read && !st_q.done) begin
      st_d.rdata = read_value(bus_req.address, readback, st_q.mask, st_q.flags); // [RL11]
      st_d.rd_flags = '0;
      if (reg_hit(bus_req.address, IDX_TICK_FLAGS)) begin
        st_d.rd_flags = st_q.flags;
      end
    end
    // only the mask register takes written data; flags and taps ignore it
    if (wr_lane0 && reg_hit(bus_req.address, IDX_TICK_MASK)) begin
      st_d.mask = bus_req.writedata[EVT_W-1:0]; // [RL4]
    end
    // set wins over clear; the mask does not gate the set
    st_d.flags = (st_q.flags & ~evt_clr) | evt_set; // [RL3] [RL7] [RL8]
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q.done <= 1'b0;
      st_q.mask <= MASK_RST; // [RL5]
      st_q.flags <= FLAGS_RST; // [RL10]
      st_q.rd_flags <= FLAGS_RST;
      st_q.rdata <= RDATA_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus_rsp.readdata = st_q.rdata;
  assign bus_rsp.waitrequest = req & ~st_q.done;
  assign irq = |(st_q.flags & st_q.mask); // [RL17]
  assign watchdog_clk_2hz = count[TAP_EVT2]; // [RL16]

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------

  logic [CNT_W-1:0] cnt_inc;
  logic rd_taps_acc;
  logic rd_flags_acc;
  logic rd_ctrl_acc;
  logic wr_flags_acc;
  logic wr_mask_acc;
  logic wr_ctrl_acc;
  logic wr_taps_acc;
  logic wr_clear_acc;
  logic rd_mask_acc;

  assign cnt_inc = count + {{(CNT_W-1){1'b0}}, 1'b1};
  assign rd_taps_acc = acc_rd & reg_hit(bus_req.address, IDX_TAP_READBACK);
  assign rd_flags_acc = acc_rd & reg_hit(bus_req.address, IDX_TICK_FLAGS);
  assign rd_ctrl_acc = acc_rd & reg_hit(bus_req.address, IDX_RUN_CTRL);
  assign wr_flags_acc = acc_wr & reg_hit(bus_req.address, IDX_TICK_FLAGS);
  assign wr_mask_acc = wr_lane0 & reg_hit(bus_req.address, IDX_TICK_MASK);
  assign wr_ctrl_acc = wr_lane0 & reg_hit(bus_req.address, IDX_RUN_CTRL);
  assign wr_taps_acc = acc_wr & reg_hit(bus_req.address, IDX_TAP_READBACK);
  assign wr_clear_acc = wr_lane0 & reg_hit(bus_req.address, IDX_FLAG_CLEAR);
  assign rd_mask_acc = acc_rd & reg_hit(bus_req.address, IDX_TICK_MASK);

  chk_counter_step: assert property ( // [RL1]
    @(posedge sys_clk) disable iff (!rst_b)
    (tick_256hz && !restart_pulse) |=> (count == $past(cnt_inc))
  ) else $error("divider did not advance on a prescaler tick");

  chk_counter_hold: assert property ( // [RL1]
    @(posedge sys_clk) disable iff (!rst_b)
    (!tick_256hz && !restart_pulse) |=> $stable(count)
  ) else $error("divider moved without a prescaler tick");

  chk_edge_event: assert property ( // [RL2]
    @(posedge sys_clk) disable iff (!rst_b)
    ($fell(count[TAP_EVT32]) || $fell(count[TAP_EVT8]) || $fell(count[TAP_EVT2]))
    |=> (st_q.flags & $past(evt_set)) == $past(evt_set)
  ) else $error("falling tap edge did not set its flag");

  chk_flag_unmasked: assert property ( // [RL3]
    @(posedge sys_clk) disable iff (!rst_b)
    (evt_set[EVT_BIT2] && !st_q.mask[EVT_BIT2]) |=> st_q.flags[EVT_BIT2]
  ) else $error("masked 2 Hz edge failed to set its flag");

  chk_mask_write: assert property ( // [RL4]
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_lane0 && reg_hit(bus_req.address, IDX_TICK_MASK))
    |=> st_q.mask == $past(bus_req.writedata[EVT_W-1:0])
  ) else $error("mask register did not take written data");

  chk_mask_reset: assert property ( // [RL5]
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(rst_b) |-> (st_q.mask == MASK_RST) [*2]
  ) else $error("mask bits not zero after reset");

  chk_flag_rdclr: assert property ( // [RL7]
    @(posedge sys_clk) disable iff (!rst_b)
    (rd_flags_acc && evt_set == '0)
    |=> (st_q.flags & $past(bus_rsp.readdata[EVT_W-1:0])) == '0
  ) else $error("flag returned by a read was not cleared");

  chk_flag_wrign: assert property ( // [RL8]
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_flags_acc && evt_set == '0) |=> $stable(st_q.flags)
  ) else $error("write to flag register changed a flag");

  chk_flag_reset: assert property ( // [RL10]
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(rst_b) |-> st_q.flags == FLAGS_RST
  ) else $error("flags not zero after reset");

  chk_taps_read: assert property ( // [RL11]
    @(posedge sys_clk) disable iff (!rst_b)
    rd_taps_acc |-> bus_rsp.readdata == {{(DATA_W-READ_W){1'b0}}, $past(readback)}
  ) else $error("tap readback does not match divider stages");

  chk_taps_reset: assert property ( // [RL12]
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(rst_b) |-> readback == CNT_RST[READ_W-1:0]
  ) else $error("tap readback not zero after reset");

  chk_restart_clear: assert property ( // [RL13]
    @(posedge sys_clk) disable iff (!rst_b)
    restart_pulse |=> count == CNT_RST
      ##1 (count == $past(cnt_inc) || (!$past(tick_256hz) && count == CNT_RST))
  ) else $error("restart did not clear and resume the divider");

  chk_restart_read: assert property ( // [RL14]
    @(posedge sys_clk) disable iff (!rst_b)
    rd_ctrl_acc |-> bus_rsp.readdata[BIT_RESTART] == 1'b0
  ) else $error("restart bit read back as one");

  chk_wdog_clock: assert property ( // [RL16]
    @(posedge sys_clk) disable iff (!rst_b)
    $fell(watchdog_clk_2hz) |=> st_q.flags[EVT_BIT2]
  ) else $error("watchdog clock edge without a 2 Hz event");

  chk_irq_raise: assert property ( // [RL17]
    @(posedge sys_clk) disable iff (!rst_b)
    (evt_set[EVT_BIT32] && st_q.mask[EVT_BIT32]) |=> irq
  ) else $error("enabled 32 Hz event raised no interrupt");

  chk_irq_quiet: assert property ( // [RL17]
    @(posedge sys_clk) disable iff (!rst_b)
    (st_q.mask == '0) |-> !irq
  ) else $error("interrupt raised while all sources masked");

  chk_bus_answer: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (req && bus_rsp.waitrequest) |=> !bus_rsp.waitrequest
  ) else $error("bus access not answered in one cycle");

  chk_flag_sticky: assert property ( // [RL3]
    @(posedge sys_clk) disable iff (!rst_b)
    (evt_clr == '0) |=> (st_q.flags & $past(st_q.flags)) == $past(st_q.flags)
  ) else $error("flag dropped without a read or clear");

  chk_flag_noset: assert property ( // [RL2]
    @(posedge sys_clk) disable iff (!rst_b)
    (evt_set == '0) |=> (st_q.flags & ~$past(st_q.flags)) == '0
  ) else $error("flag set without a tap edge");

  chk_event_32hz: assert property ( // [RL2]
    @(posedge sys_clk) disable iff (!rst_b)
    $fell(count[TAP_EVT32]) |-> evt_set[EVT_BIT32]
  ) else $error("32 Hz falling edge raised no event");

  chk_event_8hz: assert property ( // [RL2]
    @(posedge sys_clk) disable iff (!rst_b)
    $fell(count[TAP_EVT8]) |-> evt_set[EVT_BIT8]
  ) else $error("8 Hz falling edge raised no event");

  chk_event_quiet: assert property ( // [RL2]
    @(posedge sys_clk) disable iff (!rst_b)
    (!tick_256hz && !restart_pulse) |=> (evt_set == '0)
  ) else $error("event raised while the divider stood still");

  chk_mask_hold: assert property ( // [RL4]
    @(posedge sys_clk) disable iff (!rst_b)
    !wr_mask_acc |=> $stable(st_q.mask)
  ) else $error("mask changed without a mask write");

  chk_mask_read: assert property ( // [RL4]
    @(posedge sys_clk) disable iff (!rst_b)
    rd_mask_acc |-> bus_rsp.readdata == {{(DATA_W-EVT_W){1'b0}}, st_q.mask}
  ) else $error("mask read returned wrong bits");

  chk_flags_read: assert property ( // [RL7]
    @(posedge sys_clk) disable iff (!rst_b)
    rd_flags_acc |-> bus_rsp.readdata[EVT_W-1:0] == $past(st_q.flags)
  ) else $error("flag read returned wrong bits");

  chk_upper_zero: assert property ( // [RL11]
    @(posedge sys_clk) disable iff (!rst_b)
    acc_rd |-> bus_rsp.readdata[DATA_W-1:READ_W] == '0
  ) else $error("unused read data bits not zero");

  chk_restart_zero: assert property ( // [RL13]
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_ctrl_acc && !bus_req.writedata[BIT_RESTART] && !tick_256hz) |=> $stable(count)
  ) else $error("writing zero to the restart bit moved the divider");

  chk_taps_wrign: assert property ( // [RL11]
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_taps_acc && !tick_256hz) |=> $stable(count)
  ) else $error("write to tap readback moved the divider");

  chk_flag_clear: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_clear_acc && evt_set == '0)
    |=> (st_q.flags & $past(bus_req.writedata[EVT_W-1:0])) == '0
  ) else $error("clear register left a flag set");

  chk_irq_8hz: assert property ( // [RL17]
    @(posedge sys_clk) disable iff (!rst_b)
    (st_q.flags[EVT_BIT8] && st_q.mask[EVT_BIT8]) |-> irq
  ) else $error("enabled 8 Hz flag raised no interrupt");

  chk_irq_clear: assert property ( // [RL17]
    @(posedge sys_clk) disable iff (!rst_b)
    (st_q.flags == '0) |-> !irq
  ) else $error("interrupt raised with no flag set");

  chk_wdog_tap: assert property ( // [RL16]
    @(posedge sys_clk) disable iff (!rst_b)
    watchdog_clk_2hz == readback[READ_W-1]
  ) else $error("watchdog clock differs from the 2 Hz stage");

  chk_bus_wait: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(req) |-> bus_rsp.waitrequest
  ) else $error("new bus access answered without a wait cycle");

  chk_accept_done: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (req && !bus_rsp.waitrequest) |=> !st_q.done
  ) else $error("handshake state not cleared after an answer");

endmodule // tick_timer

// >>> tick_timer_pkg.sv
// shared constants, register map and carrier types of the divider tap timer
package tick_timer_pkg;

  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;
  localparam int BE_W = 4;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_TAP_READBACK = 10'h2e0;
  localparam logic [IDX_W-1:0] IDX_TICK_MASK = 10'h2e8;
  localparam logic [IDX_W-1:0] IDX_TICK_FLAGS = 10'h2e9;
  localparam logic [IDX_W-1:0] IDX_RUN_CTRL = 10'h2ee;
  localparam logic [IDX_W-1:0] IDX_FLAG_CLEAR = 10'h2f0;

  // divider geometry
  localparam int CNT_W = 7;
  localparam int EVT_W = 3;
  localparam int READ_W = 4;

  // counter stage positions: stage n toggles at 128 Hz / 2**n
  localparam int TAP_EVT32 = 2;
  localparam int TAP_READ_LO = 3;
  localparam int TAP_EVT8 = 4;
  localparam int TAP_EVT2 = 6;

  // event bit positions in the mask, flag and clear registers
  localparam int EVT_BIT32 = 0;
  localparam int EVT_BIT8 = 1;
  localparam int EVT_BIT2 = 2;

  // restart command position in the run control register
  localparam int BIT_RESTART = 3;

  // values after reset
  localparam logic [EVT_W-1:0] MASK_RST = 3'h0;
  localparam logic [EVT_W-1:0] FLAGS_RST = 3'h0;
  localparam logic [CNT_W-1:0] CNT_RST = 7'h00;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // answer latency of the bus slave, in clock cycles
  localparam int BUS_WAIT_CYCLES = 1;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [BE_W-1:0] byteenable;
    logic [DATA_W-1:0] writedata;
  } avmm_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
  } avmm_rsp_s;

  typedef struct packed {
    logic done;
    logic [EVT_W-1:0] mask;
    logic [EVT_W-1:0] flags;
    logic [EVT_W-1:0] rd_flags;
    logic [DATA_W-1:0] rdata;
  } timer_state_s;

endpackage

// >>> tap_divider.sv
// seven stage binary divider with synchronous restart and falling edge flags
`timescale 1ns/100ps
module tap_divider #(
  parameter int CNT_W = 7
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // control
  input wire logic tick,
  input wire logic restart,
  // divider stages
  output logic [CNT_W-1:0] count,
  output logic [CNT_W-1:0] fall
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] prev;
  } div_state_s;

  div_state_s st_q;
  div_state_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.prev = st_q.cnt;
    // restart wins over a tick in the same cycle
    if (restart) begin
      st_d.cnt = '0;
    end else if (tick) begin
      st_d.cnt = st_q.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0; // [RL12]
    end else begin
      st_q <= st_d;
    end
  end

  assign count = st_q.cnt;
  // a stage that went from one to zero at the last edge
  assign fall = st_q.prev & ~st_q.cnt;

endmodule // tap_divider

// >>> tick_source.sv
// prescaler model: one-cycle ticks with a chosen gap while running
`timescale 1ns/100ps
module tick_source (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic [1:0] gap,
  // tick out
  output logic tick
);
  logic [1:0] wait_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick <= 1'b0;
      wait_q <= 2'h0;
    end else if (!run || wait_q != 2'h0) begin
      tick <= 1'b0;
      wait_q <= (wait_q != 2'h0) ? wait_q - 2'h1 : 2'h0;
    end else begin
      tick <= 1'b1;
      wait_q <= gap;
    end
  end
endmodule // tick_source

// >>> test_tick_timer.sv
// self-checking bench of the divider tap timer
`timescale 1ns/100ps
module test_tick_timer;
  import tick_timer_pkg::*;
  logic sys_clk, rst_b, tick, run, irq, wdog;
  logic [1:0] gap;
  avmm_req_s req;
  avmm_rsp_s rsp;
  logic [6:0] m_cnt, old, fell;
  logic [2:0] m_mask, m_flags;
  logic [31:0] d;
  logic acc, wr0;
  int errors, cmp_count, seed, cyc, k;

  tick_timer dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .tick_256hz(tick), .bus_req(req),
    .bus_rsp(rsp), .irq(irq), .watchdog_clk_2hz(wdog));
  tick_source src_u (.sys_clk(sys_clk), .rst_b(rst_b), .run(run), .gap(gap), .tick(tick));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // reference model, sampled at the same edges as the design
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      m_cnt = 7'h00;
      m_mask = 3'h0;
      m_flags = 3'h0;
    end else begin
      acc = (req.read | req.write) && rsp.waitrequest === 1'b0;
      wr0 = acc && req.write && req.byteenable[0];
      old = m_cnt;
      if (wr0 && req.address == 12'hbb8 && req.writedata[3]) m_cnt = 7'h00;
      else if (tick) m_cnt = m_cnt + 7'h01;
      fell = old & ~m_cnt;
      if (wr0 && req.address == 12'hbc0) m_flags = m_flags & ~req.writedata[2:0];
      m_flags = m_flags | {fell[6], fell[4], fell[2]};
      if (wr0 && req.address == 12'hba0) m_mask = req.writedata[2:0];
      if (acc && req.read && req.address == 12'hba4) m_flags = 3'h0;
    end
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // the bench acts as the processor and holds each access until waitrequest drops
  task automatic bus_go(input logic rd, input logic [11:0] a, input logic [31:0] w);
    @(posedge sys_clk);
    req.read <= rd;
    req.write <= ~rd;
    req.address <= a;
    req.writedata <= w;
    do begin
      @(posedge sys_clk);
    end while (rsp.waitrequest !== 1'b0);
    d = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    bus_go(1'b1, a, 32'h0);
    chk(d, exp);
  endtask

  task automatic spin(input int n);
    gap <= 2'($random(seed));
    run <= 1'b1;
    repeat (n) @(posedge sys_clk);
    run <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  initial begin
    seed = 20;
    errors = 0;
    cmp_count = 0;
    cyc = 0;
    run = 1'b0;
    gap = 2'h0;
    req = '0;
    req.byteenable = 4'hf;
    rst_b = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdchk(12'hb80, 32'h0);
    rdchk(12'hba0, 32'h0);
    rdchk(12'hba4, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test reset values done");
    for (k = 0; k < 8; k++) begin
      bus_go(1'b0, 12'hba0, {$random(seed)} & 32'hffff_fff0 | k);
      rdchk(12'hba0, k);
      spin(200 + {$random(seed)} % 300);
      chk({31'h0, irq}, {31'h0, |(m_flags & m_mask)});
      chk({31'h0, wdog}, {31'h0, m_cnt[6]});
      bus_go(1'b0, 12'hb80, $random(seed));
      bus_go(1'b0, 12'hba4, 32'h7);
      bus_go(1'b0, 12'hbc0, 32'h1 << (k % 3));
      rdchk(12'hb80, {28'h0, m_cnt[6:3]});
      rdchk(12'hba4, {29'h0, m_flags});
      rdchk(12'hba4, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    $display("test masks and flags done");
    spin(300);
    bus_go(1'b0, 12'hbb8, 32'h7);
    rdchk(12'hb80, {28'h0, m_cnt[6:3]});
    for (k = 0; k < 3; k++) begin
      spin(150 + {$random(seed)} % 200);
      bus_go(1'b0, 12'hbb8, 32'h8);
      repeat (3) @(posedge sys_clk);
      rdchk(12'hb80, 32'h0);
      rdchk(12'hbb8, 32'h0);
      chk({31'h0, wdog}, 32'h0);
      rdchk(12'hba4, {29'h0, m_flags});
    end
    run <= 1'b1;
    repeat (100) @(posedge sys_clk);
    bus_go(1'b0, 12'hbb8, 32'h8);
    spin(40);
    rdchk(12'hb80, {28'h0, m_cnt[6:3]});
    rdchk(12'hba4, {29'h0, m_flags});
    $display("test restart done");
    bus_go(1'b0, 12'hffc, 32'hffff_ffff);
    rdchk(12'hffc, 32'h0);
    req.byteenable <= 4'he;
    bus_go(1'b0, 12'hba0, 32'h0);
    rdchk(12'hba0, 32'h7);
    req.byteenable <= 4'hf;
    $display("test unmapped done");
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdchk(12'hb80, 32'h0);
    rdchk(12'hba0, 32'h0);
    rdchk(12'hba4, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test second reset done");
    wrap_up();
  end
endmodule // test_tick_timer
